//--- core/ovh_serial_port.sv
// overhead serial insert (transmit) and extract (receive) ports
// Behaviour
// - each port has device clock, device frame pulse and one data line.
// - receive port sends recovered overhead words of each frame outward.
// - transmit port accepts 221 programmable nine-bit word slots per frame.
// - transmit frame pulse fires once per frame, about 4.1 kHz from the 20 MHz reference.
// - port clock divided from transmit clock; dummy words even out rate (here divided from the 20 MHz REF_CLK instead).
// - prefix one makes external word replace the internal value.
// - prefix and dummy word in dummy slots are always ignored.
// - a complete received frame is applied to the next outgoing frame.
// - error-mask slots send external word XOR internal value when enabled.
// - pointer locations 2 to 192 carry concatenation indications.
// - extended ports carry no path overhead bytes.
// - ports occupy general-purpose pins, excluding other pin functions.
// - positions 0, 1, 3 hold framing and growth, same for all channels.
// - position 5 is parity mask on transmit, parity XOR on receive.
// - pointer word at position 13 affects only first pointer occurrence.
// - positions 17 to 208 line parity masks, per-byte XOR on receive.
`include "ovh_serial_map.svh"
`timescale 1ns/1ns
`default_nettype none

module ovh_serial_port #(
  parameter int HALF_DIV = `OVH_HALF_DIV_DEFAULT,
  parameter int SLOTS = `OVH_SLOTS_PER_FRAME
)
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // pin claim
  input wire logic OVH_PORT_EN,
  output logic OVH_PINS_CLAIMED,
  // transmit overhead port pins
  output logic TX_OVH_CLK_OUT,
  output logic TX_OVH_FRAME_PULSE,
  input wire logic TX_OVH_DATA_IN,
  // transmit framer lookup
  input wire logic [7:0] TX_OVH_POS,
  input wire logic TX_OVH_FIRST,
  input wire logic [8:0] TX_OVH_INT,
  output logic [8:0] TX_OVH_VAL,
  output logic TX_OVH_OVR,
  // receive overhead port pins
  output logic RX_OVH_CLK_OUT,
  output logic RX_OVH_FRAME_PULSE,
  output logic RX_OVH_DATA_OUT,
  // receive framer words
  input wire logic RX_OVH_VALID,
  output logic RX_OVH_READY,
  input wire logic [7:0] RX_OVH_POS,
  input wire logic [8:0] RX_OVH_DATA,
  input wire logic [8:0] RX_OVH_EXP
);

  localparam logic [7:0] LAST_SLOT = 8'(SLOTS - 1);
  localparam logic [3:0] LAST_BIT = 4'(`OVH_SLOT_BITS - 1);
  localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);

  // ****************************************
  // port clock divider
  // ****************************************
  // a 20 MHz reference cannot reach the nominal port rate; the divider
  // gives the fastest even rate at or below it
  logic [7:0] half_cnt_reg;
  logic port_clk_reg;
  logic half_tick;
  logic fall_evt;

  assign half_tick = (half_cnt_reg == HALF_LAST);
  assign fall_evt = half_tick && port_clk_reg && OVH_PORT_EN;

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      half_cnt_reg <= 8'h00;
      port_clk_reg <= 1'b0;
    end
    else if (!OVH_PORT_EN)
    begin
      half_cnt_reg <= 8'h00;
      port_clk_reg <= 1'b0;
    end
    else if (half_tick)
    begin
      half_cnt_reg <= 8'h00;
      port_clk_reg <= ~port_clk_reg;
    end
    else
      half_cnt_reg <= half_cnt_reg + 8'h01;
  end

  assign TX_OVH_CLK_OUT = port_clk_reg;
  assign RX_OVH_CLK_OUT = port_clk_reg;

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      OVH_PINS_CLAIMED <= 1'b0;
    else
      OVH_PINS_CLAIMED <= OVH_PORT_EN;
  end

  // ****************************************
  // frame position
  // ****************************************
  // bit and slot name the port clock period now in progress; bit moves
  // on each falling edge of the port clock, slot only when bit wraps to 0
  logic [3:0] bit_reg;
  logic [7:0] slot_reg;
  logic [3:0] bit_next;
  logic [7:0] slot_next;
  logic frame_end;
  logic fp_reg;

  assign frame_end = (slot_reg == LAST_SLOT) && (bit_reg == LAST_BIT);

  always_comb
  begin
    bit_next = bit_reg + 4'h1;
    slot_next = slot_reg;
    if (bit_reg == LAST_BIT)
    begin
      bit_next = 4'h0;
      slot_next = frame_end ? 8'h00 : slot_reg + 8'h01;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      bit_reg <= 4'h0;
      slot_reg <= 8'h00;
    end
    else if (!OVH_PORT_EN)
    begin
      bit_reg <= 4'h0;
      slot_reg <= 8'h00;
    end
    else if (fall_evt)
    begin
      bit_reg <= bit_next;
      slot_reg <= slot_next;
    end
  end

  // pulse covers the last bit period, so the next rise starts slot 0
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      fp_reg <= 1'b0;
    else if (!OVH_PORT_EN)
      fp_reg <= 1'b0;
    else if (fall_evt)
      fp_reg <= (slot_next == LAST_SLOT) && (bit_next == LAST_BIT);
  end

  assign TX_OVH_FRAME_PULSE = fp_reg;
  assign RX_OVH_FRAME_PULSE = fp_reg;

  // ****************************************
  // transmit capture
  // ****************************************
  // partner launches on the rising edge; sampling on the falling edge
  // gives half a period of margin either way
  logic [8:0] tx_sh_reg;
  logic [8:0] tx_word;
  logic tx_prefix;
  logic tx_word_done;
  logic [8:0] shadow_mem [SLOTS];
  logic [SLOTS-1:0] shadow_en_reg;
  logic [8:0] active_mem [SLOTS];
  logic [SLOTS-1:0] active_en_reg;

  assign tx_word = {tx_sh_reg[7:0], TX_OVH_DATA_IN};
  assign tx_prefix = tx_sh_reg[8];
  assign tx_word_done = fall_evt && (bit_reg == LAST_BIT) &&
    (ovh_pkg::slot_kind(slot_reg) != ovh_pkg::OVH_KIND_DUMMY);

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      tx_sh_reg <= `OVH_WORD_RESET;
    else if (fall_evt)
      tx_sh_reg <= tx_word;
  end

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      shadow_en_reg <= '0;
    else if (tx_word_done)
      shadow_en_reg[slot_reg] <= tx_prefix;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (tx_word_done && tx_prefix)
      shadow_mem[slot_reg] <= tx_word;
  end

  // the whole frame moves over at once so an outgoing frame never mixes
  // words of two partner frames
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      active_en_reg <= '0;
    else if (!OVH_PORT_EN)
      active_en_reg <= '0;
    else if (fall_evt && frame_end)
      active_en_reg <= shadow_en_reg;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (fall_evt && frame_end)
    begin
      for (int i = 0; i < SLOTS; i++)
        active_mem[i] <= shadow_mem[i];
    end
  end

  // ****************************************
  // transmit overhead lookup
  // ****************************************
  // one position serves every channel of a replicated byte; pointer
  // positions only reach the first occurrence, the later ones keep the
  // framer's concatenation indication
  ovh_pkg::ovh_kind_t tx_kind;
  logic tx_use;
  logic [8:0] tx_ext;

  assign tx_kind = ovh_pkg::slot_kind(TX_OVH_POS);
  assign tx_ext = (TX_OVH_POS < 8'(SLOTS)) ? active_mem[TX_OVH_POS] :
    `OVH_WORD_RESET;

  always_comb
  begin
    tx_use = 1'b0;
    if (OVH_PORT_EN && TX_OVH_POS < 8'(SLOTS))
      tx_use = active_en_reg[TX_OVH_POS];
    if (tx_kind == ovh_pkg::OVH_KIND_DUMMY)
      tx_use = 1'b0;
    if (tx_kind == ovh_pkg::OVH_KIND_PTR && !TX_OVH_FIRST)
      tx_use = 1'b0;
  end

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      TX_OVH_VAL <= `OVH_WORD_RESET;
      TX_OVH_OVR <= 1'b0;
    end
    else
    begin
      TX_OVH_OVR <= tx_use;
      if (!tx_use)
        TX_OVH_VAL <= TX_OVH_INT;
      else if (tx_kind == ovh_pkg::OVH_KIND_MASK)
        TX_OVH_VAL <= TX_OVH_INT ^ tx_ext;
      else
        TX_OVH_VAL <= tx_ext;
    end
  end

  // ****************************************
  // receive word buffer
  // ****************************************
  ovh_pkg::ovh_kind_t rx_in_kind;
  logic [8:0] rx_in_word;
  logic rx_in_valid;
  logic buf_valid;
  logic buf_pop;
  logic [16:0] buf_data;
  logic [7:0] head_pos;
  logic [8:0] head_word;

  assign rx_in_kind = ovh_pkg::slot_kind(RX_OVH_POS);
  assign rx_in_word = (rx_in_kind == ovh_pkg::OVH_KIND_MASK) ?
    RX_OVH_DATA ^ RX_OVH_EXP : RX_OVH_DATA;
  assign rx_in_valid = RX_OVH_VALID && (RX_OVH_POS < 8'(SLOTS));

  ovh_pair_buf #(
    .WIDTH(17)
  ) u_rx_buf (
    .clk(REF_CLK),
    .nrst(NRST),
    .in_valid(rx_in_valid),
    .in_ready(RX_OVH_READY),
    .in_data({RX_OVH_POS, rx_in_word}),
    .out_valid(buf_valid),
    .out_ready(buf_pop),
    .out_data(buf_data)
  );

  assign head_pos = buf_data[16:9];
  assign head_word = buf_data[8:0];

  // ****************************************
  // receive serializer
  // ****************************************
  // a word that missed its slot is dropped rather than shifted into a
  // wrong position
  ovh_pkg::ovh_rx_state_t rx_state_reg;
  logic [8:0] rx_sh_reg;
  logic rx_load;
  logic rx_stale;

  assign rx_load = fall_evt && (bit_next == 4'h0) && buf_valid &&
    (head_pos == slot_next);
  assign rx_stale = buf_valid && (head_pos < slot_reg);
  assign buf_pop = rx_load || rx_stale;

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rx_state_reg <= ovh_pkg::OVH_RX_GAP;
      rx_sh_reg <= `OVH_WORD_RESET;
      RX_OVH_DATA_OUT <= 1'b0;
    end
    else if (!OVH_PORT_EN)
    begin
      rx_state_reg <= ovh_pkg::OVH_RX_GAP;
      rx_sh_reg <= `OVH_WORD_RESET;
      RX_OVH_DATA_OUT <= 1'b0;
    end
    else if (fall_evt && bit_next == 4'h0)
    begin
      RX_OVH_DATA_OUT <= rx_load;
      rx_sh_reg <= rx_load ? head_word : `OVH_WORD_RESET;
      rx_state_reg <= rx_load ? ovh_pkg::OVH_RX_WORD : ovh_pkg::OVH_RX_GAP;
    end
    else if (fall_evt)
    begin
      case (rx_state_reg)
        ovh_pkg::OVH_RX_WORD:
        begin
          RX_OVH_DATA_OUT <= rx_sh_reg[8];
          rx_sh_reg <= {rx_sh_reg[7:0], 1'b0};
        end
        ovh_pkg::OVH_RX_GAP:
          RX_OVH_DATA_OUT <= 1'b0;
        default:
          rx_state_reg <= ovh_pkg::OVH_RX_GAP;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- core/ovh_serial_map.svh
// constants for the overhead serial insert and extract ports
`ifndef OVH_SERIAL_MAP_SVH
`define OVH_SERIAL_MAP_SVH

// ****************************************
// word and slot shape
// ****************************************
`define OVH_WORD_BITS 9
`define OVH_SLOT_BITS 10
`define OVH_WORD_RESET 9'h000

// ****************************************
// timing
// ****************************************
`define OVH_FRAME_RATE_HZ 8000
`define OVH_PORT_RATE_HZ 19440000
`define OVH_REF_CLK_HZ 20000000
`define OVH_SLOTS_PER_FRAME \
  (`OVH_PORT_RATE_HZ / `OVH_FRAME_RATE_HZ / `OVH_SLOT_BITS)
// half period of the port clock in reference cycles, rounded up
`define OVH_HALF_DIV_DEFAULT \
  ((`OVH_REF_CLK_HZ + 2 * `OVH_PORT_RATE_HZ - 1) / (2 * `OVH_PORT_RATE_HZ))

// ****************************************
// serial positions
// ****************************************
`define OVH_POS_FRAMING_1 8'h00
`define OVH_POS_FRAMING_2 8'h01
`define OVH_POS_SECT_GROWTH 8'h03
`define OVH_POS_SECT_PARITY 8'h05
`define OVH_POS_PTR_1 8'h0D
`define OVH_POS_PTR_2 8'h0E
`define OVH_POS_LINE_PAR_FIRST 8'h11
`define OVH_POS_LINE_PAR_LAST 8'hD0
`define OVH_POS_LAST_DEFINED 8'hE4
`define OVH_POS_DUMMY_0 8'h04
`define OVH_POS_DUMMY_1 8'h08
`define OVH_POS_DUMMY_2 8'h0C
`define OVH_POS_DUMMY_3 8'h10
`define OVH_POS_DUMMY_4 8'hD3
`define OVH_POS_DUMMY_5 8'hD7
`define OVH_POS_DUMMY_6 8'hDB
`define OVH_POS_DUMMY_7 8'hDF

`endif

//--- core/ovh_pkg.sv
// types and slot decoding for the overhead serial ports
`include "ovh_serial_map.svh"

package ovh_pkg;

  typedef enum logic [1:0] {
    OVH_KIND_PLAIN = 2'b00,
    OVH_KIND_MASK = 2'b01,
    OVH_KIND_PTR = 2'b10,
    OVH_KIND_DUMMY = 2'b11
  } ovh_kind_t;

  typedef enum logic {
    OVH_RX_GAP = 1'b0,
    OVH_RX_WORD = 1'b1
  } ovh_rx_state_t;

  // what a serial position carries
  function automatic ovh_kind_t slot_kind(input logic [7:0] pos);
    ovh_kind_t k;
    k = OVH_KIND_PLAIN;
    if (pos > `OVH_POS_LAST_DEFINED)
      k = OVH_KIND_DUMMY;
    else if (pos == `OVH_POS_DUMMY_0 || pos == `OVH_POS_DUMMY_1 ||
             pos == `OVH_POS_DUMMY_2 || pos == `OVH_POS_DUMMY_3 ||
             pos == `OVH_POS_DUMMY_4 || pos == `OVH_POS_DUMMY_5 ||
             pos == `OVH_POS_DUMMY_6 || pos == `OVH_POS_DUMMY_7)
      k = OVH_KIND_DUMMY;
    else if (pos == `OVH_POS_SECT_PARITY ||
             (pos >= `OVH_POS_LINE_PAR_FIRST &&
              pos <= `OVH_POS_LINE_PAR_LAST))
      k = OVH_KIND_MASK;
    else if (pos == `OVH_POS_PTR_1 || pos == `OVH_POS_PTR_2)
      k = OVH_KIND_PTR;
    return k;
  endfunction

endpackage

//--- core/ovh_pair_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module ovh_pair_buf #(
  parameter int WIDTH = 17
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem [2];
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic in_ready_reg;
  logic push;
  logic pop;

  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem[rd_ptr_reg];
  assign in_ready = in_ready_reg;
  assign push = in_valid && in_ready_reg;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 2'h1;
    else if (pop && !push)
      count_next = count_reg - 2'h1;
  end

  // ready is registered so the filling side sees a clean level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_reg <= 2'h0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      in_ready_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      in_ready_reg <= (count_next != 2'h2);
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

endmodule

`default_nettype wire

//--- verification/ovh_serial_port_asserts.sv
// concurrent checks on the overhead serial port pins
`timescale 1ns/1ns
`default_nettype none

module ovh_serial_port_asserts #(
  parameter int HALF_DIV = 1,
  parameter int SLOTS = 243
)
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // enable
  input wire logic OVH_PORT_EN,
  input wire logic OVH_PINS_CLAIMED,
  // transmit side
  input wire logic TX_OVH_CLK_OUT,
  input wire logic TX_OVH_FRAME_PULSE,
  input wire logic [7:0] TX_OVH_POS,
  input wire logic TX_OVH_FIRST,
  input wire logic [8:0] TX_OVH_INT,
  input wire logic [8:0] TX_OVH_VAL,
  input wire logic TX_OVH_OVR,
  // receive side
  input wire logic RX_OVH_CLK_OUT,
  input wire logic RX_OVH_FRAME_PULSE,
  input wire logic RX_OVH_DATA_OUT,
  input wire logic RX_OVH_READY
);
  localparam int FRAME = SLOTS * 20 * HALF_DIV;
  logic [15:0] gap_reg;
  logic pulse_d_reg;
  logic seen_reg;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  // ********
  // frame spacing, forgotten while the port is off
  // ********
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      gap_reg <= 16'h0000;
      pulse_d_reg <= 1'b0;
      seen_reg <= 1'b0;
    end
    else
    begin
      pulse_d_reg <= TX_OVH_FRAME_PULSE;
      gap_reg <= (TX_OVH_FRAME_PULSE && !pulse_d_reg) ? 16'h0000 :
                 gap_reg + 16'h0001;
      seen_reg <= OVH_PORT_EN && (seen_reg || TX_OVH_FRAME_PULSE);
    end
  end

  // the first edge after reset still shows the reset value of the copy
  property p_claim;
    $past(NRST) |-> OVH_PINS_CLAIMED == $past(OVH_PORT_EN);
  endproperty
  a_claim: assert property (p_claim) else $error("claim lags");
  property p_mirror;
    RX_OVH_CLK_OUT == TX_OVH_CLK_OUT &&
    RX_OVH_FRAME_PULSE == TX_OVH_FRAME_PULSE;
  endproperty
  a_mirror: assert property (p_mirror) else $error("rx pins differ");
  property p_width;
    $rose(TX_OVH_FRAME_PULSE) |->
      TX_OVH_FRAME_PULSE[*2] ##1 !TX_OVH_FRAME_PULSE;
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_period;
    TX_OVH_FRAME_PULSE && !pulse_d_reg && seen_reg |->
      gap_reg == 16'(FRAME - 1);
  endproperty
  a_period: assert property (p_period) else $error("frame length");
  property p_idle;
    !OVH_PORT_EN[*3] |-> !TX_OVH_CLK_OUT && !TX_OVH_FRAME_PULSE &&
      !RX_OVH_DATA_OUT && !TX_OVH_OVR;
  endproperty
  a_idle: assert property (p_idle) else $error("port not idle");
  property p_plain;
    !TX_OVH_OVR |-> TX_OVH_VAL == $past(TX_OVH_INT);
  endproperty
  a_plain: assert property (p_plain) else $error("internal value");
  property p_dummy;
    $past(TX_OVH_POS) > 8'hE4 || $past(TX_OVH_POS) == 8'h04 |-> !TX_OVH_OVR;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy used");
  property p_ptr;
    ($past(TX_OVH_POS) == 8'h0D || $past(TX_OVH_POS) == 8'h0E) &&
      !$past(TX_OVH_FIRST) |-> !TX_OVH_OVR;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer repeat");
  property p_rx_edge;
    OVH_PORT_EN && $past(OVH_PORT_EN) && $changed(RX_OVH_DATA_OUT) |->
      $fell(RX_OVH_CLK_OUT);
  endproperty
  a_rx_edge: assert property (p_rx_edge) else $error("rx bit edge");
  c_ovr: cover property (TX_OVH_OVR);
  c_full: cover property ($fell(RX_OVH_READY));
  c_prefix: cover property ($rose(RX_OVH_DATA_OUT));
endmodule
`default_nettype wire

//--- verification/ovh_fpga_model.sv
// far-side model: feeds transmit words, records receive words
`timescale 1ns/1ns
`default_nettype none

module ovh_fpga_model #(
  parameter int SLOTS = 243
)
(
  // transmit overhead port
  input wire logic tx_clk,
  input wire logic tx_pulse,
  output logic tx_data,
  // receive overhead port
  input wire logic rx_clk,
  input wire logic rx_pulse,
  input wire logic rx_data
);
  logic [9:0] rx_word [SLOTS];
  logic [9:0] w;
  int idx = -1;
  int ridx = -1;

  // ********
  // prefix then word; every third slot from 1 left disabled
  // ********
  function automatic logic [9:0] tx_word(input int s);
    return {(s % 3) != 1, 9'(s) ^ 9'h0A5};
  endfunction

  initial tx_data = 1'b0;

  // outside a frame the line keeps changing so stale bits never match
  always @(posedge tx_clk)
  begin
    if (tx_pulse)
      idx = 0;
    if (!tx_pulse && idx >= 0 && idx < SLOTS * 10)
    begin
      w = tx_word(idx / 10);
      tx_data <= w[9 - idx % 10];
      idx = idx + 1;
    end
    else
      tx_data <= ~tx_data;
  end

  always @(posedge rx_clk)
  begin
    if (rx_pulse)
      ridx = 0;
    else if (ridx >= 0 && ridx < SLOTS * 10)
    begin
      rx_word[ridx / 10][9 - ridx % 10] = rx_data;
      ridx = ridx + 1;
    end
  end
endmodule
`default_nettype wire

//--- verification/ovh_serial_port_test.sv
// self-checking bench for the overhead serial ports
`timescale 1ns/1ns
`default_nettype none

module ovh_serial_port_test;
  localparam int HALF_DIV = 1;
  localparam int SLOTS = 243;
  typedef struct {
    logic [7:0] pos;
    logic first;
    logic [8:0] inp;
    logic [8:0] val;
    logic ovr;
  } ovh_row_t;
  logic REF_CLK;
  logic NRST;
  logic OVH_PORT_EN;
  logic OVH_PINS_CLAIMED;
  logic TX_OVH_CLK_OUT;
  logic TX_OVH_FRAME_PULSE;
  logic TX_OVH_DATA_IN;
  logic [7:0] TX_OVH_POS;
  logic TX_OVH_FIRST;
  logic [8:0] TX_OVH_INT;
  logic [8:0] TX_OVH_VAL;
  logic TX_OVH_OVR;
  logic RX_OVH_CLK_OUT;
  logic RX_OVH_FRAME_PULSE;
  logic RX_OVH_DATA_OUT;
  logic RX_OVH_VALID;
  logic RX_OVH_READY;
  logic [7:0] RX_OVH_POS;
  logic [8:0] RX_OVH_DATA;
  logic [8:0] RX_OVH_EXP;
  int bad_count;
  int check_count;
  ovh_row_t rows [11] = '{
    '{8'h00, 1'b1, 9'h1FF, 9'h0A5, 1'b1}, '{8'h01, 1'b1, 9'h1FF, 9'h1FF, 1'b0},
    '{8'h03, 1'b1, 9'h000, 9'h0A6, 1'b1}, '{8'h05, 1'b1, 9'h10F, 9'h1AF, 1'b1},
    '{8'h08, 1'b1, 9'h055, 9'h055, 1'b0}, '{8'h0E, 1'b1, 9'h000, 9'h0AB, 1'b1},
    '{8'h0E, 1'b0, 9'h011, 9'h011, 1'b0}, '{8'h11, 1'b1, 9'h1F0, 9'h144, 1'b1},
    '{8'hCF, 1'b1, 9'h000, 9'h06A, 1'b1}, '{8'hD1, 1'b1, 9'h0AA, 9'h074, 1'b1},
    '{8'hE6, 1'b1, 9'h033, 9'h033, 1'b0}};

  ovh_serial_port #(.HALF_DIV(HALF_DIV), .SLOTS(SLOTS)) u_ovh_serial_port (
    .REF_CLK(REF_CLK), .NRST(NRST), .OVH_PORT_EN(OVH_PORT_EN),
    .OVH_PINS_CLAIMED(OVH_PINS_CLAIMED), .TX_OVH_CLK_OUT(TX_OVH_CLK_OUT),
    .TX_OVH_FRAME_PULSE(TX_OVH_FRAME_PULSE), .TX_OVH_DATA_IN(TX_OVH_DATA_IN),
    .TX_OVH_POS(TX_OVH_POS), .TX_OVH_FIRST(TX_OVH_FIRST),
    .TX_OVH_INT(TX_OVH_INT), .TX_OVH_VAL(TX_OVH_VAL), .TX_OVH_OVR(TX_OVH_OVR),
    .RX_OVH_CLK_OUT(RX_OVH_CLK_OUT), .RX_OVH_FRAME_PULSE(RX_OVH_FRAME_PULSE),
    .RX_OVH_DATA_OUT(RX_OVH_DATA_OUT), .RX_OVH_VALID(RX_OVH_VALID),
    .RX_OVH_READY(RX_OVH_READY), .RX_OVH_POS(RX_OVH_POS),
    .RX_OVH_DATA(RX_OVH_DATA), .RX_OVH_EXP(RX_OVH_EXP));

  ovh_fpga_model #(.SLOTS(SLOTS)) u_ovh_fpga_model (
    .tx_clk(TX_OVH_CLK_OUT), .tx_pulse(TX_OVH_FRAME_PULSE),
    .tx_data(TX_OVH_DATA_IN), .rx_clk(RX_OVH_CLK_OUT),
    .rx_pulse(RX_OVH_FRAME_PULSE), .rx_data(RX_OVH_DATA_OUT));

  // ********
  // shared tasks
  // ********
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    check_count++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic look(input logic [7:0] p, input logic f, input logic [8:0] v);
    @(posedge REF_CLK);
    TX_OVH_POS <= p;
    TX_OVH_FIRST <= f;
    TX_OVH_INT <= v;
    @(posedge REF_CLK);
    #1;
  endtask

  // returns on the edge at which the word was taken
  task automatic offer(input logic [7:0] p, input logic [8:0] d,
                       input logic [8:0] e);
    RX_OVH_VALID <= 1'b1;
    RX_OVH_POS <= p;
    RX_OVH_DATA <= d;
    RX_OVH_EXP <= e;
    @(posedge REF_CLK);
    while (RX_OVH_READY !== 1'b1)
      @(posedge REF_CLK);
  endtask

  task automatic wait_pulse(input logic lvl);
    int n;
    n = 0;
    while (TX_OVH_FRAME_PULSE !== lvl && n < 6000)
    begin
      @(posedge REF_CLK);
      n++;
    end
    // a pulse that never comes counts against the run
    if (n >= 6000)
      bad_count++;
  endtask

  initial
  begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    bad_count++;
    report_and_stop;
  end

  initial
  begin
    bad_count = 0;
    check_count = 0;
    NRST = 1'b0;
    OVH_PORT_EN = 1'b1;
    TX_OVH_POS = 8'h00;
    TX_OVH_FIRST = 1'b0;
    TX_OVH_INT = 9'h000;
    RX_OVH_VALID = 1'b0;
    RX_OVH_POS = 8'h00;
    RX_OVH_DATA = 9'h000;
    RX_OVH_EXP = 9'h000;
    repeat (8) @(posedge REF_CLK);
    check(10'(RX_OVH_READY), 10'h000);
    NRST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    #1;
    check(10'(RX_OVH_READY), 10'h001);
    look(8'h00, 1'b1, 9'h1FF);
    check(10'(TX_OVH_OVR), 10'h000);
    $display("reset test done");
    wait_pulse(1'b1);
    wait_pulse(1'b0);
    offer(8'h05, 9'h1F0, 9'h0F0);
    offer(8'h06, 9'h1A5, 9'h000);
    RX_OVH_VALID <= 1'b0;
    #1;
    check(10'(RX_OVH_READY), 10'h000);
    wait_pulse(1'b1);
    wait_pulse(1'b0);
    check(u_ovh_fpga_model.rx_word[5], 10'h300);
    check(u_ovh_fpga_model.rx_word[6], 10'h3A5);
    check(u_ovh_fpga_model.rx_word[7], 10'h000);
    check(10'(RX_OVH_READY), 10'h001);
    // positions past the frame must never occupy the buffer
    offer(8'hF5, 9'h1FF, 9'h000);
    offer(8'hF6, 9'h1FF, 9'h000);
    RX_OVH_VALID <= 1'b0;
    #1;
    check(10'(RX_OVH_READY), 10'h001);
    $display("receive test done");
    foreach (rows[i])
    begin
      look(rows[i].pos, rows[i].first, rows[i].inp);
      check(10'(TX_OVH_VAL), 10'(rows[i].val));
      check(10'(TX_OVH_OVR), 10'(rows[i].ovr));
    end
    $display("lookup test done");
    @(posedge REF_CLK);
    OVH_PORT_EN <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    #1;
    check(10'(OVH_PINS_CLAIMED), 10'h000);
    look(8'h00, 1'b1, 9'h077);
    check(10'(TX_OVH_VAL), 10'h077);
    $display("disable test done");
    @(posedge REF_CLK);
    NRST <= 1'b0;
    #1;
    check(10'(TX_OVH_VAL), 10'h000);
    @(posedge REF_CLK);
    NRST <= 1'b1;
    $display("second reset test done");
    report_and_stop;
  end
endmodule

bind ovh_serial_port ovh_serial_port_asserts #(.HALF_DIV(HALF_DIV),
  .SLOTS(SLOTS)) u_ovh_serial_port_asserts (
  .REF_CLK(REF_CLK), .NRST(NRST), .OVH_PORT_EN(OVH_PORT_EN),
  .OVH_PINS_CLAIMED(OVH_PINS_CLAIMED), .TX_OVH_CLK_OUT(TX_OVH_CLK_OUT),
  .TX_OVH_FRAME_PULSE(TX_OVH_FRAME_PULSE), .TX_OVH_POS(TX_OVH_POS),
  .TX_OVH_FIRST(TX_OVH_FIRST), .TX_OVH_INT(TX_OVH_INT),
  .TX_OVH_VAL(TX_OVH_VAL), .TX_OVH_OVR(TX_OVH_OVR),
  .RX_OVH_CLK_OUT(RX_OVH_CLK_OUT), .RX_OVH_FRAME_PULSE(RX_OVH_FRAME_PULSE),
  .RX_OVH_DATA_OUT(RX_OVH_DATA_OUT), .RX_OVH_READY(RX_OVH_READY));
`default_nettype wire
